/* File: hdl/swm_master.sv */
// Purpose: Master frame engine for a single-wire push-pull bus.
// Assumes: Bus pin is open drain; a low from anyone wins on the wire.
// Notes: Push bytes queue in a FIFO; each byte becomes one whole frame.
`timescale 1ns/10ps
`default_nettype none
module swm_master
  import swm_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        single_wire_mode_enable,
  input  wire logic [12:0] baud_divisor,
  input  wire logic        send_break_bit,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic        bus_receive_pin,
  output logic             bus_tx_out,
  output logic             bus_tx_oe,
  output logic [7:0]       frame_data_low_byte,
  output logic             rx_done,
  output logic             frame_ok,
  output logic             bus_error,
  output logic             noise_error_flag,
  input  wire logic        noise_clear,
  output logic             busy
);

  // Two-stage synchroniser on the bus receive pin.
  logic       rx_s1_q;
  logic       rx_s2_q;
  // Slot divider: baud prescaler then sixteen ticks.
  logic [12:0] pre_q;
  logic [3:0]  tick_q;
  wire         tick_w;
  wire         slot_end_w;
  wire         slot_mid_w;
  // Engine state and counters.
  swm_state_t  st_q;
  logic [4:0]  cnt_q;
  logic        half_q;
  logic [7:0]  sh_q;
  logic [2:0]  code_q;
  logic        last_q;
  logic        toggled_q;
  logic        stuck_q;
  logic        line_q;
  // FIFO output.
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  wire         fifo_pop;
  wire         push_bit_w;
  wire         mismatch_w;

  swm_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_data   (tx_byte),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Synchronise the monitored bus level.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= bus_receive_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // RULE_19 slot divider chain
  // Prescaler by the divisor, then sixteen ticks make one slot.
  assign tick_w     = (pre_q == 13'h0001) || (pre_q == 13'h0000);
  assign slot_end_w = tick_w && (tick_q == 4'(SWM_TICKS_PER_SLOT - 1));
  assign slot_mid_w = tick_w && (tick_q == 4'(SWM_TICKS_PER_SLOT / 2));

  // Divider counts only while a frame or break runs; idle reloads the divisor.
  // Loading the divisor in idle keeps the first slot as long as the others.
  always_ff @(posedge clk)
  begin
    if (srst || st_q == SWM_IDLE)
    begin
      pre_q  <= srst ? SWM_BAUD_RST : baud_divisor;
      tick_q <= '0;
    end
    else if (tick_w)
    begin
      pre_q  <= baud_divisor;
      tick_q <= tick_q + 4'h1;
    end
    else
      pre_q <= pre_q - 13'h0001;
  end

  // RULE_23 idle byte starts frame
  // RULE_21 mode enable gates engine
  assign fifo_pop = (st_q == SWM_IDLE) && single_wire_mode_enable && !send_break_bit;

  // RULE_09 biphase-L halves
  // Zero is high then low; one is low then high; sync is a zero.
  assign push_bit_w = (cnt_q == 5'h00) ? 1'b0 : sh_q[0];

  // RULE_15 monitor pushed bits
  assign mismatch_w = slot_mid_w && (st_q == SWM_PUSH || st_q == SWM_PSYNC)
                      && (rx_s2_q != line_q);

  // Line level driven by the engine; low is dominant.
  always_comb
  begin
    case (st_q)
      // RULE_02 dominant start slots
      SWM_START: line_q = 1'b0;
      // RULE_03 sync and bits
      SWM_PUSH:  line_q = half_q ? push_bit_w : !push_bit_w;
      // RULE_06 pull sync one
      SWM_PSYNC: line_q = half_q;
      // RULE_22 break holds low
      SWM_BRK:   line_q = 1'b0;
      default:   line_q = 1'b1;
    endcase
  end

  // RULE_18 open drain drive
  // Only a low is driven; the high level comes from the pull-up.
  assign bus_tx_out = 1'b0;
  assign bus_tx_oe  = !line_q;
  assign busy       = (st_q != SWM_IDLE);

  // Frame sequencing.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q   <= SWM_IDLE;
      cnt_q  <= '0;
      half_q <= 1'b0;
      sh_q   <= '0;
    end
    else
    begin
      case (st_q)
        SWM_IDLE:
        begin
          cnt_q  <= '0;
          half_q <= 1'b0;
          if (send_break_bit && single_wire_mode_enable)
            st_q <= SWM_BRK;
          else if (fifo_pop && fifo_valid)
          begin
            // RULE_05 data low, address high
            // RULE_01 frame opens with start
            sh_q <= fifo_data;
            st_q <= SWM_START;
          end
        end
        SWM_START:
          if (slot_end_w)
          begin
            if (cnt_q == 5'(SWM_START_SLOTS - 1))
            begin
              cnt_q <= '0;
              st_q  <= SWM_PUSH;
            end
            else
              cnt_q <= cnt_q + 5'h01;
          end
        SWM_PUSH:
          if (slot_end_w)
          begin
            half_q <= !half_q;
            if (half_q)
            begin
              // RULE_04 five data three address
              if (cnt_q != 5'h00)
                sh_q <= {1'b0, sh_q[7:1]};
              if (cnt_q == 5'(SWM_PUSH_BITS))
              begin
                cnt_q <= '0;
                st_q  <= SWM_PSYNC;
              end
              else
                cnt_q <= cnt_q + 5'h01;
            end
          end
        SWM_PSYNC:
          if (slot_end_w)
          begin
            half_q <= !half_q;
            if (half_q)
              st_q <= SWM_PULL;
          end
        SWM_PULL:
          if (slot_end_w)
          begin
            if (cnt_q == 5'(SWM_PULL_BITS - 1))
            begin
              cnt_q <= '0;
              st_q  <= SWM_EOF;
            end
            else
              cnt_q <= cnt_q + 5'h01;
          end
        SWM_EOF:
          if (slot_end_w)
          begin
            if (cnt_q == 5'(SWM_EOF_SLOTS - 1))
              st_q <= SWM_IDLE;
            else
              cnt_q <= cnt_q + 5'h01;
          end
        SWM_BRK:
          if (slot_end_w)
          begin
            if (cnt_q == 5'(SWM_BREAK_SLOTS - 1))
              st_q <= SWM_IDLE;
            else
              cnt_q <= cnt_q + 5'h01;
          end
        default: st_q <= SWM_IDLE;
      endcase
    end
  end

  // Pull sampling and end-of-frame watch, sampled mid slot.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      code_q    <= '0;
      last_q    <= 1'b1;
      toggled_q <= 1'b0;
      stuck_q   <= 1'b1;
    end
    else if (st_q == SWM_PSYNC)
    begin
      toggled_q <= 1'b0;
      stuck_q   <= 1'b1;
    end
    else if (slot_mid_w && st_q == SWM_PULL)
    begin
      // RULE_07 shift NRZ pull bits
      code_q <= {code_q[1:0], rx_s2_q};
      last_q <= rx_s2_q;
    end
    else if (slot_mid_w && st_q == SWM_EOF)
    begin
      last_q <= rx_s2_q;
      // Square wave at push bit rate: level alternates every slot, checked at odd slots.
      if (cnt_q[0] && rx_s2_q != last_q)
        toggled_q <= 1'b1;
      if (!rx_s2_q)
        stuck_q <= 1'b0;
    end
  end

  wire frame_end_w = (st_q == SWM_EOF) && slot_end_w
                     && (cnt_q == 5'(SWM_EOF_SLOTS - 1));

  // Frame result and receive byte.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      frame_data_low_byte <= '0;
      rx_done             <= 1'b0;
      frame_ok            <= 1'b0;
      bus_error           <= 1'b0;
    end
    else
    begin
      rx_done <= frame_end_w;
      if (frame_end_w)
      begin
        // RULE_07 code into receive byte
        frame_data_low_byte <= SWM_RX_FRAME_BITS | {4'h0, code_q, 1'b0};
        // RULE_10 valid frame check
        frame_ok  <= (code_q != SWM_CODE_ONES) && (code_q != SWM_CODE_ZEROS)
                     && toggled_q;
        // RULE_11 error pattern check
        bus_error <= (code_q == SWM_CODE_ONES) && stuck_q;
      end
    end
  end

  // RULE_16 sticky noise flag
  // A new error in the clearing cycle wins over the clear.
  always_ff @(posedge clk)
  begin
    if (srst)
      noise_error_flag <= 1'b0;
    else if (mismatch_w)
      noise_error_flag <= 1'b1;
    else if (noise_clear)
      noise_error_flag <= 1'b0;
  end

  // RULE_16 mismatch sets flag
  a_noise_set: assert property (@(posedge clk) disable iff (srst) // RULE_16
    mismatch_w |=> noise_error_flag)
    else $error("noise flag not set after bit error");

  a_start_low: assert property (@(posedge clk) disable iff (srst) // RULE_02
    (st_q == SWM_START) |-> bus_tx_oe)
    else $error("start slot not dominant");

  a_start_entry: assert property (@(posedge clk) disable iff (srst) // RULE_01
    (st_q == SWM_PUSH && $past(st_q) != SWM_PUSH) |->
    ($past(st_q) == SWM_START))
    else $error("push entered without start");

  a_push_order: assert property (@(posedge clk) disable iff (srst) // RULE_04
    (st_q == SWM_PUSH && $past(st_q) == SWM_START) |-> cnt_q == 5'h00 && !half_q)
    else $error("push did not begin at sync bit");

  a_psync_one: assert property (@(posedge clk) disable iff (srst) // RULE_06
    (st_q == SWM_PSYNC) |-> (bus_tx_oe == !half_q))
    else $error("pull sync not a biphase one");

  a_psync_entry: assert property (@(posedge clk) disable iff (srst) // RULE_06
    (st_q == SWM_PSYNC && $past(st_q) == SWM_PUSH) |->
    (!half_q && $past(cnt_q) == 5'(SWM_PUSH_BITS)))
    else $error("pull sync not right after last address bit");

  a_biphase_halves: assert property (@(posedge clk) disable iff (srst) // RULE_09
    (st_q == SWM_PUSH && cnt_q == 5'h00) |-> (bus_tx_oe == half_q))
    else $error("push sync not a biphase zero");

  a_ok_exclusive: assert property (@(posedge clk) disable iff (srst) // RULE_10
    rx_done |-> !(frame_ok && bus_error))
    else $error("frame both good and failed");

  a_break_low: assert property (@(posedge clk) disable iff (srst) // RULE_22
    (st_q == SWM_BRK) |-> bus_tx_oe && busy)
    else $error("break not driving low");

  a_code_reject: assert property (@(posedge clk) disable iff (srst) // RULE_11
    (frame_end_w && code_q == SWM_CODE_ONES) |=> !frame_ok)
    else $error("all-ones code accepted");

  c_frame_ok:  cover property (@(posedge clk) rx_done && frame_ok);
  c_bus_error: cover property (@(posedge clk) rx_done && bus_error);
  c_break:     cover property (@(posedge clk) st_q == SWM_BRK);
  c_noise:     cover property (@(posedge clk) mismatch_w);

endmodule
`default_nettype wire

/* File: hdl/swm_pkg.sv */
// Purpose: Constants for the single-wire push-pull master frame engine.
// Assumes: 20 MHz system clock; time slots of 16 divider ticks each.
// Notes: Every offset, reset value and timing count is named once here.
//
// Contract
// RULE_01 - Frame opens: start, sync, data, address.
// RULE_02 - Start is three dominant low slots.
// RULE_03 - Push sync is biphase zero.
// RULE_04 - Five data bits, then three address bits.
// RULE_05 - Data low five bits, address high three.
// RULE_06 - Pull sync biphase one after address.
// RULE_07 - NRZ pull bits land in receive byte.
// RULE_08 - Slave ends good frame with square wave.
// RULE_09 - Biphase-L: zero high-low, one low-high.
// RULE_10 - Success needs mixed code plus square wave.
// RULE_11 - All ones plus steady high is error.
// RULE_12 - Slave flags noise on disagreeing samples.
// RULE_13 - Slave flags biphase error on equal halves.
// RULE_14 - Slave flags field error on bad format.
// RULE_15 - Monitor bus while pushing, detect mismatches.
// RULE_16 - Push bit error sets noise flag.
// RULE_17 - Slaves disable after eight low slots.
// RULE_18 - Low dominant, high recessive, low wins.
// RULE_19 - Slot clock is master clock divided sixteen.
// RULE_20 - Slave answers pull without further request.
// RULE_21 - Mode enable selects single-wire behaviour.
// RULE_22 - Send break drives low twenty slots.
// RULE_23 - Byte written while idle queues frame.
package swm_pkg;

  // Divider ticks per time slot.
  localparam int unsigned SWM_TICKS_PER_SLOT = 16;
  // Dominant slots forming the start.
  localparam int unsigned SWM_START_SLOTS    = 3;
  // Push data and address widths.
  localparam int unsigned SWM_DATA_BITS      = 5;
  localparam int unsigned SWM_ADDR_BITS      = 3;
  // Push bits after the sync bit.
  localparam int unsigned SWM_PUSH_BITS      = 8;
  // Pull status bits returned by the slave.
  localparam int unsigned SWM_PULL_BITS      = 3;
  // End-of-frame watch length in slots.
  localparam int unsigned SWM_EOF_SLOTS      = 8;
  // Break length in slots.
  localparam int unsigned SWM_BREAK_SLOTS    = 20;
  // Reset value of the baud prescaler count.
  localparam logic [12:0] SWM_BAUD_RST       = 13'h0001;
  // Pull code values that mark a failed frame.
  localparam logic [2:0]  SWM_CODE_ONES      = 3'h7;
  localparam logic [2:0]  SWM_CODE_ZEROS     = 3'h0;
  // Fixed pattern around the pull code in the receive byte.
  localparam logic [7:0]  SWM_RX_FRAME_BITS  = 8'h51;

  // Frame engine states, one-hot.
  typedef enum logic [6:0] {
    SWM_IDLE  = 7'h01,
    SWM_START = 7'h02,
    SWM_PUSH  = 7'h04,
    SWM_PSYNC = 7'h08,
    SWM_PULL  = 7'h10,
    SWM_EOF   = 7'h20,
    SWM_BRK   = 7'h40
  } swm_state_t;

endpackage

/* File: hdl/swm_fifo.sv */
// Purpose: Small valid/ready FIFO carrying push bytes into the engine.
// Assumes: One clock, synchronous active-high reset.
// Notes: Depth must be a power of two.
`timescale 1ns/10ps
`default_nettype none
module swm_fifo
  import swm_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  // Storage array and pointers with one extra wrap bit.
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push_w;
  wire              pop_w;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push_w    = in_valid && in_ready;
  assign pop_w     = out_valid && out_ready;

  // Pointer update.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push_w)
        wr_q <= wr_q + 1'b1;
      if (pop_w)
        rd_q <= rd_q + 1'b1;
    end
  end

  // Data array write; not reset since contents only matter once valid.
  always_ff @(posedge clk)
  begin
    if (push_w)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

endmodule
`default_nettype wire

/* File: tb/swm_slave_model.sv */
// Purpose: Behavioural slave on the single-wire bus, answering every frame.
// Assumes: The wire has a pull-up; a low from any party wins.
// Notes: Pull code and end-of-frame shape are chosen by the bench.
`timescale 1ns/10ps
`default_nettype none
module swm_slave_model
(
  input  wire logic       clk,
  input  wire logic       bus_level,
  input  wire logic [5:0] slot_len,
  input  wire logic [2:0] pull_code,
  input  wire logic       eof_square,
  input  wire logic       corrupt,
  output logic            pull_low,
  output logic [22:0]     slots_seen
);
  logic       a;    // First sample of a slot.
  logic       b;    // Second sample of a slot.
  logic       bad;  // Some slave-side error seen in this frame.
  logic       sq;   // Square wave wanted at end of frame.
  logic [2:0] code; // Code actually returned.
  initial pull_low = 1'b0;
  // Frame follower: samples the push, then answers on the same wire.
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (bus_level === 1'b0)
      begin
        bad = 1'b0;
        for (int k = 0; k < 23; k++)
        begin
          // The bench may glitch the sync bit's high half low.
          pull_low <= corrupt && (k == 3);
          repeat (slot_len / 4) @(posedge clk);
          a = bus_level;
          repeat (slot_len / 2) @(posedge clk);
          b = bus_level;
          repeat (slot_len / 4) @(posedge clk);
          if (a !== b) bad = 1'b1;
          slots_seen[k] = b;
        end
        pull_low <= 1'b0;
        if (slots_seen[4:0] !== 5'h08 || slots_seen[22:21] !== 2'h2) bad = 1'b1;
        for (int i = 0; i < 8; i++) if (slots_seen[5+2*i] === slots_seen[6+2*i]) bad = 1'b1;
        code = bad ? 3'h7 : pull_code;
        sq = !bad && eof_square;
        if (slots_seen[7:0] !== 8'h00)
        begin
          for (int k = 0; k < 3; k++)
          begin
            pull_low <= !code[2-k];
            repeat (slot_len) @(posedge clk);
          end
          for (int k = 0; k < 8; k++)
          begin
            pull_low <= sq && (k % 2 == 0);
            repeat (slot_len) @(posedge clk);
          end
          pull_low <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_single_wire_push_pull_master.sv */
// Purpose: Self-checking bench for the single-wire master frame engine.
// Assumes: One slave model on the wire; pull-up keeps it high when free.
// Notes: Divisor 1 gives 16-clock slots; one case runs at divisor 2.
`timescale 1ns/10ps
`default_nettype none
module test_single_wire_push_pull_master;
  import swm_pkg::*;
  logic clk = 0, srst = 1, mode_en = 0, brk = 0, tx_valid = 0, ready, oe, out;
  logic [12:0] baud = 13'h0001;
  logic [7:0] tx_byte = 8'h00, rx_byte;
  logic rx_done, ok, err, noise, nclr = 0, busy, pl, sq = 1, corrupt = 0;
  logic [5:0] slen = 6'h10;
  logic [2:0] code = 3'h5;
  logic [22:0] seen;
  int num_errors = 0, samples_checked = 0;
  int busy_clks = 0;  // Clock edges seen with the engine busy.
  // Counts busy edges so a whole frame's length can be judged.
  always @(posedge clk)
    if (busy === 1'b1)
      busy_clks <= busy_clks + 1;
  // Wire level: open-drain master and slave against the pull-up.
  wire bus = (oe ? out : 1'b1) & ~pl;
  always #25 clk = ~clk;
  swm_master #(.FIFO_DEPTH(16)) i_dut (.clk(clk), .srst(srst),
    .single_wire_mode_enable(mode_en), .baud_divisor(baud), .send_break_bit(brk),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(ready), .bus_receive_pin(bus),
    .bus_tx_out(out), .bus_tx_oe(oe), .frame_data_low_byte(rx_byte), .rx_done(rx_done),
    .frame_ok(ok), .bus_error(err), .noise_error_flag(noise), .noise_clear(nclr),
    .busy(busy));
  swm_slave_model i_slave (.clk(clk), .bus_level(bus), .slot_len(slen), .pull_code(code),
    .eof_square(sq), .corrupt(corrupt), .pull_low(pl), .slots_seen(seen));

  task automatic finish_test();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One comparison, counted; a mismatch is reported at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %0h seen %0h", what, exp, got);
      num_errors++;
    end
  endtask

  // Expected slot levels: start, sync, eight biphase bits, pull sync.
  function automatic logic [22:0] exp_slots(input logic [7:0] b);
    logic [22:0] v;
    v = 23'h400008;
    for (int i = 0; i < 8; i++)
    begin
      v[5+2*i] = ~b[i];
      v[6+2*i] = b[i];
    end
    return v;
  endfunction

  task automatic push(input logic [7:0] b);
    for (int n = 0; n < 3000; n++)
    begin
      @(negedge clk);
      if (ready === 1'b1)
      begin
        tx_valid = 1;
        tx_byte = b;
        @(negedge clk);
        tx_valid = 0;
        return;
      end
    end
    num_errors++;
    finish_test();
  endtask

  task automatic wait_done();
    for (int n = 0; n < 2000; n++)
    begin
      @(negedge clk);
      if (rx_done === 1'b1) return;
    end
    num_errors++;
    finish_test();
  endtask

  // Checks one finished frame against the byte and the slave's answer.
  task automatic judge(input logic [7:0] b, input logic eok, input logic eerr);
    check("slots", {9'h0, exp_slots(b)}, {9'h0, seen});
    check("rx byte", SWM_RX_FRAME_BITS | {code, 1'b0}, rx_byte);
    check("frame ok", eok, ok);
    check("bus error", eerr, err);
  endtask

  task automatic frame(input logic [7:0] b, input logic [2:0] c, input logic s,
                       input logic eok, input logic eerr);
    @(negedge clk);
    code = c;
    sq = s;
    push(b);
    wait_done();
    judge(b, eok, eerr);
  endtask

  task automatic t_reset();
    check("oe", 0, oe);
    check("idle", 32'h1, {busy, ready});
    check("flags", 0, {rx_byte, ok, err, noise});
  endtask

  task automatic t_codes();
    logic [7:0] fb [5] = '{8'hA3, 8'h1C, 8'h5E, 8'hE1, 8'hFF};
    logic [2:0] fc [5] = '{3'h5, 3'h7, 3'h0, 3'h2, 3'h1};
    logic [4:0] fs = 5'h15, fo = 5'h11, fe = 5'h02;
    for (int i = 0; i < 5; i++) frame(fb[i], fc[i], fs[i], fo[i], fe[i]);
    check("no noise", 0, noise);
  endtask

  task automatic t_bit_error();
    corrupt = 1;
    code = 3'h5;
    push(8'h6A);
    wait_done();
    check("noise set", 1, noise);
    check("slave error", 32'h1, {ok, err});
    corrupt = 0;
    nclr = 1;
    @(negedge clk);
    nclr = 0;
    @(negedge clk);
    check("noise clear", 0, noise);
  endtask

  task automatic t_baud();
    baud = 13'h0002;
    slen = 6'h20;
    busy_clks = 0;
    frame(8'h3B, 3'h6, 1, 1, 0);
    check("frame clocks", 34 * 32, busy_clks);
    baud = 13'h0001;
    slen = 6'h10;
  endtask

  task automatic t_break();
    int n;
    n = 0;
    brk = 1;
    @(negedge clk);
    brk = 0;
    for (int i = 0; i < 400 && (oe !== 1'b0 || n == 0); i++)
    begin
      if (oe === 1'b1) n++;
      @(negedge clk);
    end
    if (oe !== 1'b0)
    begin
      num_errors++;
      finish_test();
    end
    check("break clocks", 20 * 16, n);
    repeat (200) @(negedge clk);
    check("no frame", 0, {busy, pl});
  endtask

  task automatic t_mode_fifo();
    mode_en = 0;
    for (int i = 0; i < 16; i++) push(8'h10 + i);
    @(negedge clk);
    check("fifo full", 32'h0, {ready, busy, oe});
    mode_en = 1;
    for (int i = 0; i < 16; i++)
    begin
      wait_done();
      judge(8'h10 + i, 1, 0);
    end
    check("drained", 32'h1, ready);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 0;
    t_reset();
    t_mode_fifo();
    t_codes();
    t_bit_error();
    t_baud();
    t_break();
    finish_test();
  end
endmodule
`default_nettype wire
